// ===== shared/ssf_pkg.sv
// Package for the synchronous serial channel: register map, control layout, states.
`default_nettype none
package ssf_pkg;
    // ==========================================================================
    // Register offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BRG = 8'h04;
    localparam logic [7:0] ADDR_TXBUF = 8'h08;
    localparam logic [7:0] ADDR_RXBUF = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
    // ==========================================================================
    // Control register layout, bit 0 is tx_en.
    typedef struct packed {
        logic [1:0] fi_sel;
        logic rx_dir;
        logic clk_dir;
        logic sync_mode;
        logic open_drain;
        logic clk_pin_sel;
        logic two_pin_en;
        logic line_inv;
        logic data_inv;
        logic msb_first;
        logic clk_pol;
        logic cont_rx;
        logic hs_disable;
        logic ext_clk;
        logic hs_func;
        logic rx_en;
        logic tx_en;
    } ssf_ctrl_type;
    // Sticky event layout shared by status, clear and enable registers.
    typedef struct packed {
        logic ovr;
        logic rxd;
        logic txe;
    } ssf_irq_type;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SHIFT = 2'b10} ssf_state_type;
    // ==========================================================================
    // Reset values and counts.
    localparam logic [17:0] CTRL_RST = 18'h00000;
    localparam logic [7:0] BRG_RST = 8'h00;
    localparam logic [3:0] FRAME_LAST = 4'h7;
    localparam logic [7:0] DUMMY_DATA = 8'hFF;
    localparam logic [4:0] PRE_F1 = 5'h00;
    localparam logic [4:0] PRE_F8 = 5'h07;
    localparam logic [4:0] PRE_F32 = 5'h1F;
endpackage
`default_nettype wire

// ===== core/ssf_sync_serial.sv
// Clock-synchronous serial channel with select functions and an APB register slave.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Summary of operation
// - Polarity bit picks which shift-clock edge drives and samples data.
// - Bit order bit zero sends LSB first, one sends MSB first.
// - With continuous receive on, reading the receive buffer re-arms reception.
// - Two clock output pins; select bit chooses which one carries the clock.
// - Two-pin clock choice acts only with the internal shift clock.
// - Two-pin clock option disables the handshake pin function.
// - Data logic bit inverts data on transmit write and receive read.
// - Line polarity reversal inverts serial output and input pin levels.
// - Output pin stays high or floats until the first transfer starts.
// - Receive-only frames shift dummy ones out on the output pin.
// - Serial input is used only while its direction bit is zero.
// - Clock pin drives when internal unless two-pin selects the alternate pin, accepts input when external and direction zero.
// - Handshake pin is a port, clear-to-send input or request-to-send output.
// - Each frame is exactly eight data bits with no framing bits.
// - Internal shift clock period is two times (value plus one) prescaled ticks.
// - A frame starts only when enables, buffer, handshake and idle clock allow.
// - A frame finishing on a full buffer flags overrun, overwrites, no receive event.
module ssf_sync_serial (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    input wire logic shift_clock_pin_i,
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe_n_o,
    output logic alternate_clock_output_pin_o,
    output logic alternate_clock_output_pin_oe_n_o,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_n_o,
    input wire logic serial_in_pin_i,
    input wire logic handshake_pin_i,
    output logic handshake_pin_o,
    output logic handshake_pin_oe_n_o
);
    // ========================================================================
    // State.
    typedef struct packed {
        ssf_pkg::ssf_ctrl_type ctrl;
        logic [7:0] brg;
        logic [7:0] txb;
        logic tx_full;
        logic [7:0] rxb;
        logic rx_full;
        logic rx_armed;
        logic started;
        ssf_pkg::ssf_state_type st;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic [3:0] cnt;
        logic [1:0] smp;
        logic [1:0] fin;
        logic [4:0] pre;
        logic [7:0] half;
        logic sclk;
        logic obit;
        logic ck_s1;
        logic ck_s2;
        logic ck_s3;
        logic din_s1;
        logic din_s2;
        logic cts_s1;
        logic cts_s2;
        ssf_pkg::ssf_irq_type ist;
        ssf_pkg::ssf_irq_type ien;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic ck_o;
        logic ck_oe_n;
        logic alt_o;
        logic alt_oe_n;
        logic so;
        logic so_oe_n;
        logic hs_o;
        logic hs_oe_n;
    } ssf_reg_type;

    ssf_reg_type r;
    ssf_reg_type n;
    logic acc, wr, rd, idle_lvl, two_pin, hs_off, fi_tick, lead_ev, trail_ev;
    logic din, tx_go, rx_go, ext_ok, cts_ok, done, ni, ntwo, v, cap, last;

    function automatic logic [4:0] pre_lim(input logic [1:0] sel);
        case (sel)
            2'h1: pre_lim = ssf_pkg::PRE_F8;
            2'h2: pre_lim = ssf_pkg::PRE_F32;
            default: pre_lim = ssf_pkg::PRE_F1;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= ssf_pkg::ADDR_IRQ_EN);
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic msb);
        shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
    endfunction

    // ========================================================================
    // Next state.
    always_comb begin
        n = r;
        last = 1'b0;
        lead_ev = 1'b0;
        trail_ev = 1'b0;
        acc = psel_i & penable_i & r.pready;
        wr = acc & pwrite_i;
        rd = acc & ~pwrite_i;
        idle_lvl = ~r.ctrl.clk_pol;
        two_pin = r.ctrl.two_pin_en & ~r.ctrl.ext_clk;
        hs_off = r.ctrl.hs_disable | two_pin;
        n.ck_s1 = shift_clock_pin_i;
        n.ck_s2 = r.ck_s1;
        n.ck_s3 = r.ck_s2;
        n.din_s1 = serial_in_pin_i;
        n.din_s2 = r.din_s1;
        n.cts_s1 = handshake_pin_i;
        n.cts_s2 = r.cts_s1;
        // Registered answer costs one wait-free access phase but keeps outputs on flops.
        n.pready = psel_i & ~penable_i;
        n.pslverr = psel_i & ~penable_i & ~addr_ok(paddr_i);
        n.prdata = '0;
        if (psel_i & ~penable_i & ~pwrite_i) begin
            case (paddr_i)
                ssf_pkg::ADDR_CTRL: n.prdata = {14'h0000, r.ctrl};
                ssf_pkg::ADDR_BRG: n.prdata = {24'h000000, r.brg};
                ssf_pkg::ADDR_RXBUF: n.prdata = {24'h000000, r.rxb ^ {8{r.ctrl.data_inv}}};
                ssf_pkg::ADDR_STAT: n.prdata = {27'h0000000, r.rx_armed, r.started,
                                                r.st == ssf_pkg::ST_SHIFT, r.rx_full, r.tx_full};
                ssf_pkg::ADDR_IRQ_STAT: n.prdata = {29'h00000000, r.ist};
                ssf_pkg::ADDR_IRQ_EN: n.prdata = {29'h00000000, r.ien};
                default: n.prdata = '0;
            endcase
        end
        if (rd && paddr_i == ssf_pkg::ADDR_RXBUF) begin
            n.rx_full = 1'b0;
            if (r.ctrl.cont_rx) begin
                n.rx_armed = 1'b1;
            end
        end
        if (wr && paddr_i == ssf_pkg::ADDR_IRQ_CLR) begin
            n.ist = r.ist & ~pwdata_i[2:0];
        end
        fi_tick = (r.pre == pre_lim(r.ctrl.fi_sel));
        n.pre = fi_tick ? 5'h00 : r.pre + 5'h01;
        if (r.st == ssf_pkg::ST_SHIFT) begin
            if (r.ctrl.ext_clk) begin
                // External clock accepted only with direction zero.
                lead_ev = ~r.ctrl.clk_dir & (r.ck_s3 == idle_lvl) & (r.ck_s2 != idle_lvl);
                trail_ev = ~r.ctrl.clk_dir & (r.ck_s3 != idle_lvl) & (r.ck_s2 == idle_lvl);
            end else if (fi_tick) begin
                if (r.half == r.brg) begin
                    n.half = 8'h00;
                    n.sclk = ~r.sclk;
                    // Leaving idle level is the drive edge.
                    lead_ev = (r.sclk == idle_lvl);
                    trail_ev = (r.sclk != idle_lvl);
                end else begin
                    n.half = r.half + 8'h01;
                end
            end
        end
        // Input pin ignored when used as port.
        din = r.ctrl.rx_dir ? 1'b1 : (r.din_s2 ^ r.ctrl.line_inv);
        cts_ok = hs_off | r.ctrl.hs_func | ~r.cts_s2;
        ext_ok = ~r.ctrl.ext_clk | (r.ck_s2 == idle_lvl);
        tx_go = r.ctrl.tx_en & r.tx_full & cts_ok & ext_ok;
        rx_go = r.ctrl.rx_en & r.ctrl.cont_rx & r.rx_armed & ext_ok;
        case (r.st)
            ssf_pkg::ST_IDLE: begin
                n.sclk = idle_lvl;
                n.half = 8'h00;
                if (r.ctrl.sync_mode & (tx_go | rx_go)) begin
                    n.st = ssf_pkg::ST_SHIFT;
                    n.cnt = 4'h0;
                    n.obit = 1'b1;
                    n.tx_sh = tx_go ? r.txb : ssf_pkg::DUMMY_DATA;
                    n.rx_armed = 1'b0;
                    n.started = 1'b1;
                    if (tx_go) begin
                        n.tx_full = 1'b0;
                        n.ist.txe = 1'b1;
                    end
                end
            end
            ssf_pkg::ST_SHIFT: begin
                if (lead_ev) begin
                    n.obit = r.ctrl.msb_first ? r.tx_sh[7] : r.tx_sh[0];
                    n.tx_sh = r.ctrl.msb_first ? {r.tx_sh[6:0], 1'b1} : {1'b1, r.tx_sh[7:1]};
                end
                if (trail_ev) begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == ssf_pkg::FRAME_LAST) begin
                        last = 1'b1;
                        n.st = ssf_pkg::ST_IDLE;
                    end
                end
            end
            default: n.st = ssf_pkg::ST_IDLE;
        endcase
        // Internal frames capture two cycles late, in step with the input synchroniser.
        n.smp = {r.smp[0], trail_ev};
        n.fin = {r.fin[0], last};
        cap = r.ctrl.ext_clk ? trail_ev : r.smp[1];
        done = r.ctrl.ext_clk ? last : r.fin[1];
        if (cap) begin
            n.rx_sh = shift_in(r.rx_sh, din, r.ctrl.msb_first);
        end
        if (done && r.ctrl.rx_en) begin
            n.rxb = n.rx_sh;
            if (n.rx_full) begin
                n.ist.ovr = 1'b1;
            end else begin
                n.ist.rxd = 1'b1;
            end
            n.rx_full = 1'b1;
        end
        if (wr) begin
            case (paddr_i)
                ssf_pkg::ADDR_CTRL: n.ctrl = pwdata_i[17:0];
                ssf_pkg::ADDR_BRG: n.brg = pwdata_i[7:0];
                ssf_pkg::ADDR_TXBUF: begin
                    n.txb = pwdata_i[7:0] ^ {8{r.ctrl.data_inv}};
                    n.tx_full = 1'b1;
                end
                ssf_pkg::ADDR_IRQ_EN: n.ien = pwdata_i[2:0];
                default: n.ien = n.ien;
            endcase
        end
        if (!n.ctrl.sync_mode) begin
            n.st = ssf_pkg::ST_IDLE;
            n.started = 1'b0;
        end
        n.irq = |(n.ist & n.ien);
        // Pins are derived from the next state so each output flop matches the state beside it.
        ni = ~n.ctrl.clk_pol;
        ntwo = n.ctrl.two_pin_en & ~n.ctrl.ext_clk;
        n.ck_o = (n.st == ssf_pkg::ST_SHIFT) ? n.sclk : ni;
        n.alt_o = n.ck_o;
        n.ck_oe_n = n.ctrl.ext_clk | (ntwo & n.ctrl.clk_pin_sel);
        n.alt_oe_n = ~(ntwo & n.ctrl.clk_pin_sel);
        v = n.obit ^ n.ctrl.line_inv;
        // High or floating before first frame.
        if (!n.started) begin
            v = 1'b1;
        end
        n.so = v;
        n.so_oe_n = n.ctrl.open_drain & v;
        n.hs_oe_n = n.ctrl.hs_disable | ntwo | ~n.ctrl.hs_func;
        n.hs_o = n.hs_oe_n | ~(n.ctrl.rx_en & ~n.rx_full);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.ctrl <= ssf_pkg::CTRL_RST;
            r.brg <= ssf_pkg::BRG_RST;
            r.st <= ssf_pkg::ST_IDLE;
            r.sclk <= 1'b1;
            r.ck_o <= 1'b1;
            r.alt_o <= 1'b1;
            r.alt_oe_n <= 1'b1;
            r.so <= 1'b1;
            r.hs_o <= 1'b1;
            r.hs_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign prdata_o = r.prdata;
    assign pready_o = r.pready;
    assign pslverr_o = r.pslverr;
    assign irq_o = r.irq;
    assign shift_clock_pin_o = r.ck_o;
    assign shift_clock_pin_oe_n_o = r.ck_oe_n;
    assign alternate_clock_output_pin_o = r.alt_o;
    assign alternate_clock_output_pin_oe_n_o = r.alt_oe_n;
    assign serial_out_pin_o = r.so;
    assign serial_out_pin_oe_n_o = r.so_oe_n;
    assign handshake_pin_o = r.hs_o;
    assign handshake_pin_oe_n_o = r.hs_oe_n;

    // ========================================================================
    // Assertions.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_idle_pol;
        (r.st == ssf_pkg::ST_IDLE) && !r.ctrl.ext_clk |-> (r.ck_o == ~r.ctrl.clk_pol);
    endproperty
    a_idle_pol: assert property (p_idle_pol) else $error("Idle clock level wrong.");

    property p_frame_start;
        (r.st == ssf_pkg::ST_SHIFT) && ($past(r.st) == ssf_pkg::ST_IDLE) |-> (r.cnt == 4'h0) && $past(tx_go || rx_go);
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("Frame began without start.");

    property p_frame_len;
        (r.st == ssf_pkg::ST_SHIFT) |-> (r.cnt <= 4'h7);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("Frame exceeded eight bits.");

    property p_overrun;
        done && r.ctrl.rx_en && r.rx_full && !rd |=> r.ist.ovr && (!r.ist.rxd || $past(r.ist.rxd));
    endproperty
    a_overrun: assert property (p_overrun) else $error("Overrun not flagged.");

    property p_cont_rx;
        rd && (paddr_i == ssf_pkg::ADDR_RXBUF) && r.ctrl.cont_rx && !tx_go && !rx_go |=> r.rx_armed;
    endproperty
    a_cont_rx: assert property (p_cont_rx) else $error("Read did not re-arm.");

    property p_data_inv;
        wr && (paddr_i == ssf_pkg::ADDR_TXBUF) && r.ctrl.data_inv |=> (r.txb == ~$past(pwdata_i[7:0]));
    endproperty
    a_data_inv: assert property (p_data_inv) else $error("Transmit data not inverted.");

    property p_pre_start;
        !r.started |-> serial_out_pin_o && (serial_out_pin_oe_n_o == r.ctrl.open_drain);
    endproperty
    a_pre_start: assert property (p_pre_start) else $error("Output not idle before start.");

    property p_two_pin_hs;
        r.ctrl.two_pin_en && !r.ctrl.ext_clk |-> handshake_pin_oe_n_o && handshake_pin_o;
    endproperty
    a_two_pin_hs: assert property (p_two_pin_hs) else $error("Handshake active with two-pin clock.");

    property p_ext_clk;
        r.ctrl.ext_clk |-> shift_clock_pin_oe_n_o && alternate_clock_output_pin_oe_n_o;
    endproperty
    a_ext_clk: assert property (p_ext_clk) else $error("Clock driven while external.");

    c_tx_done: cover property ((r.st == ssf_pkg::ST_SHIFT) ##1 (r.st == ssf_pkg::ST_IDLE));
    c_overrun: cover property ($rose(r.ist.ovr));
    c_rearm: cover property ($rose(r.rx_armed));
    c_ext_frame: cover property (r.ctrl.ext_clk && $rose(r.st == ssf_pkg::ST_SHIFT));
endmodule // ssf_sync_serial
`default_nettype wire

// ===== tb/ssf_peer.sv
// Behavioural model of the clock-synchronous serial peer on the far side.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Peer model
module ssf_peer (
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic pol_i,
    input wire logic msb_i,
    input wire logic sdo_i,
    input wire logic [7:0] tx_i,
    output logic sdi_o,
    output logic [7:0] rx_o
);
    int k;
    int p;
    initial begin
        k = 0;
        sdi_o = 1'b1;
        rx_o = 8'h00;
    end
    always @(posedge rst_i) begin
        k = 0;
    end
    // eight bits per frame.
    // Data is driven on the leading edge and captured on the trailing edge.
    always @(sclk_i) begin
        p = msb_i ? 7 - k : k;
        if (rst_i) begin
            k = 0;
        end else if (sclk_i === pol_i) begin
            sdi_o = tx_i[p];
        end else begin
            rx_o[p] = sdo_i;
            k = (k == 7) ? 0 : k + 1;
            // A released line must not keep its last value, or stale bits would pass.
            if (k == 0) begin
                sdi_o <= #20 ~sdi_o;
            end
        end
    end
endmodule // ssf_peer
`default_nettype wire

// ===== tb/sync_serial_select_functions_tb.sv
// Self-checking testbench for the synchronous serial channel.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Bench
module sync_serial_select_functions_tb;
    typedef struct packed {
        logic [17:0] ctrl;
        logic [7:0] brg;
        logic [7:0] txd;
        logic [7:0] ptx;
    } ssf_row_type;
    ssf_row_type rows [7] = '{'{18'h02003, 8'h00, 8'hA5, 8'h3C}, '{18'h02043, 8'h01, 8'h81, 8'h7E},
        '{18'h02083, 8'h00, 8'h96, 8'hC1}, '{18'h02103, 8'h00, 8'h0F, 8'hF0}, '{18'h02203, 8'h00, 8'h12, 8'h34},
        '{18'h123C3, 8'h00, 8'h5A, 8'h01}, '{18'h02003, 8'hFF, 8'h69, 8'hE7}};
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, er, sck_o, sck_oe_n, alt_o, alt_oe_n, sdo, sdo_oe_n, hs_o, hs_oe_n, sdi;
    logic cts_n = 1'b0;
    logic ext_sck = 1'b1;
    logic peer_rst = 1'b0, pol = 1'b0, msb = 1'b0;
    logic [7:0] ptx = 8'h00, prx, ex;
    wire logic sclk;
    int fails = 0, n_tests = 0, cyc = 0;
    // Undriven by the block, the clock wire carries the peer's clock, which idles high.
    assign sclk = !sck_oe_n ? sck_o : (!alt_oe_n ? alt_o : ext_sck);
    ssf_sync_serial i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq), .shift_clock_pin_i(sclk), .shift_clock_pin_o(sck_o),
        .shift_clock_pin_oe_n_o(sck_oe_n), .alternate_clock_output_pin_o(alt_o),
        .alternate_clock_output_pin_oe_n_o(alt_oe_n), .serial_out_pin_o(sdo), .serial_out_pin_oe_n_o(sdo_oe_n),
        .serial_in_pin_i(sdi), .handshake_pin_i(cts_n), .handshake_pin_o(hs_o), .handshake_pin_oe_n_o(hs_oe_n));
    ssf_peer i_peer (.rst_i(peer_rst), .sclk_i(sclk), .pol_i(pol), .msb_i(msb), .sdo_i(sdo), .tx_i(ptx),
        .sdi_o(sdi), .rx_o(prx));
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            results();
        end
    end
    // ========================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fails++;
            $display("ERROR %0t no pready", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(input logic [31:0] m);
        int n;
        n = 0;
        rd = 32'h0;
        while ((rd & m) == 32'h0 && n < 3000) begin
            apb(1'b0, ssf_pkg::ADDR_IRQ_STAT, 32'h0);
            n++;
        end
        if ((rd & m) == 32'h0) chk(rd, m);
    endtask
    task automatic cfg(input logic [17:0] v);
        ssf_pkg::ssf_ctrl_type c;
        c = v;
        apb(1'b1, ssf_pkg::ADDR_CTRL, {14'h0, v});
        pol <= c.clk_pol;
        msb <= c.msb_first;
        peer_rst <= 1'b1;
        tick(2);
        peer_rst <= 1'b0;
        tick(1);
    endtask
    task automatic results;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ========================================================================
    // Main sequence
    initial begin
        ssf_pkg::ssf_ctrl_type c;
        int half, e, n;
        logic prev;
        tick(8);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            c = rows[i].ctrl;
            apb(1'b1, ssf_pkg::ADDR_BRG, {24'h0, rows[i].brg});
            cfg(rows[i].ctrl);
            ptx <= rows[i].ptx;
            half = (rows[i].brg + 1) * ((c.fi_sel == 2'd1) ? 8 : (c.fi_sel == 2'd2) ? 32 : 1);
            apb(1'b1, ssf_pkg::ADDR_TXBUF, {24'h0, rows[i].txd});
            e = 0;
            n = 0;
            prev = sclk;
            while (e < 2 && n < 2000) begin
                @(posedge clk_i);
                n++;
                if (sclk !== prev) begin
                    e++;
                    if (e == 1) n = 0;
                    prev = sclk;
                end
            end
            chk(32'(n), 32'(half));
            wt(32'h2);
            chk(rd & 32'h7, 32'h3);
            ex = rows[i].txd ^ {8{c.data_inv}} ^ {8{c.line_inv}};
            chk({24'h0, prx}, {24'h0, ex});
            apb(1'b0, ssf_pkg::ADDR_RXBUF, 32'h0);
            ex = rows[i].ptx ^ {8{c.data_inv}} ^ {8{c.line_inv}};
            chk(rd, {24'h0, ex});
            apb(1'b1, ssf_pkg::ADDR_IRQ_CLR, 32'h7);
        end
        // External shift clock from the peer side, half period of eight cycles.
        cfg(18'h0200B);
        ptx <= 8'h96;
        apb(1'b1, ssf_pkg::ADDR_TXBUF, 32'h3C);
        tick(2);
        repeat (16) begin
            ext_sck <= ~ext_sck;
            tick(8);
        end
        wt(32'h2);
        chk({24'h0, prx}, 32'h3C);
        apb(1'b0, ssf_pkg::ADDR_RXBUF, 32'h0);
        chk(rd, 32'h96);
        apb(1'b1, ssf_pkg::ADDR_IRQ_CLR, 32'h7);
        // Overrun: second frame lands on an unread buffer; clear-to-send high holds the first.
        cfg(18'h02003);
        apb(1'b1, ssf_pkg::ADDR_IRQ_EN, 32'h4);
        ptx <= 8'h22;
        cts_n <= 1'b1;
        apb(1'b1, ssf_pkg::ADDR_TXBUF, 32'h11);
        tick(10);
        apb(1'b0, ssf_pkg::ADDR_STAT, 32'h0);
        chk(rd & 32'h5, 32'h1);
        cts_n <= 1'b0;
        wt(32'h2);
        chk({24'h0, prx}, 32'h11);
        apb(1'b1, ssf_pkg::ADDR_IRQ_CLR, 32'h7);
        ptx <= 8'h44;
        apb(1'b1, ssf_pkg::ADDR_TXBUF, 32'h33);
        wt(32'h4);
        chk(rd & 32'h6, 32'h4);
        tick(1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ssf_pkg::ADDR_IRQ_EN, 32'h0);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ssf_pkg::ADDR_IRQ_EN, 32'h4);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ssf_pkg::ADDR_IRQ_CLR, 32'h7);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, ssf_pkg::ADDR_RXBUF, 32'h0);
        chk(rd, 32'h44);
        // Receive only with continuous receive: each buffer read re-arms.
        cfg(18'h02022);
        ptx <= 8'hC3;
        apb(1'b0, ssf_pkg::ADDR_RXBUF, 32'h0);
        wt(32'h2);
        chk({24'h0, prx}, 32'hFF);
        apb(1'b1, ssf_pkg::ADDR_IRQ_CLR, 32'h7);
        ptx <= 8'h5A;
        apb(1'b0, ssf_pkg::ADDR_RXBUF, 32'h0);
        chk(rd, 32'hC3);
        wt(32'h2);
        apb(1'b0, ssf_pkg::ADDR_RXBUF, 32'h0);
        chk(rd, 32'h5A);
        // Second reset in mid-run, then pin functions before any transfer.
        sys_rst_i <= 1'b1;
        tick(8);
        sys_rst_i <= 1'b0;
        tick(1);
        chk({29'h0, sdo, sdo_oe_n, irq}, 32'h4);
        for (int a = 0; a < 32; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b1, ssf_pkg::ADDR_CTRL, 32'h3000);
        tick(3);
        chk({31'h0, sdo_oe_n}, 32'h1);
        apb(1'b1, ssf_pkg::ADDR_CTRL, 32'h2C04);
        tick(3);
        chk({29'h0, alt_oe_n, sck_oe_n, hs_oe_n}, 32'h3);
        apb(1'b1, ssf_pkg::ADDR_CTRL, 32'h2C0C);
        tick(3);
        chk({30'h0, alt_oe_n, sck_oe_n}, 32'h3);
        apb(1'b1, ssf_pkg::ADDR_CTRL, 32'h2004);
        tick(3);
        chk({30'h0, sck_oe_n, hs_oe_n}, 32'h0);
        apb(1'b1, ssf_pkg::ADDR_CTRL, 32'h2014);
        tick(3);
        chk({31'h0, hs_oe_n}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h02, 32'h1);
        chk({31'h0, er}, 32'h1);
        results();
    end
endmodule // sync_serial_select_functions_tb
`default_nettype wire
